// [verilog/pesd_pkg.sv]
package pesd_pkg;

    localparam logic [11:0] CTL_OFFSET = 12'h000;
    localparam logic [11:0] CTR_OFFSET = 12'h004;
    localparam logic [11:0] STAT_OFFSET = 12'h008;

    localparam int CODE_LSB = 0;
    localparam int CODE_W = 12;
    localparam int MASK_LSB = 16;
    localparam int MASK_W = 8;
    localparam int INVERT_BIT = 24;
    localparam int ENABLE_BIT = 25;

    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTR_RESET = 32'h0000_0000;

    localparam logic [11:0] EV_FPU_DISP = 12'h000;
    localparam logic [11:0] EV_FPU_EMPTY = 12'h001;
    localparam logic [11:0] EV_FAST_FLAG = 12'h002;
    localparam logic [11:0] EV_SSE_RET = 12'h003;
    localparam logic [11:0] EV_MOVE_RET = 12'h004;
    localparam logic [11:0] EV_SER_RET = 12'h005;
    localparam logic [11:0] EV_SER_SCHED = 12'h006;
    localparam logic [11:0] EV_SEG_LOAD = 12'h020;
    localparam logic [11:0] EV_SMC_RESTART = 12'h021;
    localparam logic [11:0] EV_PROBE_RESTART = 12'h022;

    localparam int SSE_FLOP_BIT = 6;
    localparam logic FPU_DP_IS_64 = 1'b1;

    typedef logic [4:0] pesd_inc_t;

    typedef struct packed {
        logic [2:0] disp_vld;
        logic [2:0] disp_ldmov;
        logic [2:0] disp_packed;
        logic fpu_empty;
        logic [1:0] fast_flag_cnt;
        logic [5:0] sse_ret;
        logic [5:0][2:0] sse_flops;
        logic [3:0] mov_ret;
        logic [3:0] ser_ret;
        logic [1:0] ser_in_sched;
        logic [6:0] seg_load;
        logic smc_restart;
        logic probe_restart;
    } pesd_events_s;

    typedef struct packed {
        logic bexec_head;
        logic bexec_oldest_unretired;
        logic bser_head;
        logic bser_oldest_unissued;
    } pesd_sched_s;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [MASK_W-1:0] mask;
        logic invert;
        logic enable;
        logic [31:0] count;
        pesd_inc_t last_inc;
        logic [31:0] rdata;
    } pesd_state_s;

endpackage

// [verilog/pesd_top.sv]
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module pesd_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pesd_pkg::pesd_events_s events,
    input wire pesd_pkg::pesd_sched_s sched,
    output logic bexec_issue_ok,
    output logic bser_issue_ok,
    output logic younger_block
);
    import pesd_pkg::*;

    pesd_state_s st_ff;
    pesd_state_s nxt_st;
    pesd_inc_t raw_inc;
    pesd_inc_t inc;
    logic decoded;
    logic mapped;
    logic setup_ph;
    logic access_ph;
    logic wr_ctl;
    logic wr_ctr;
    logic [31:0] ctl_word;
    logic [31:0] ctl_new;

    function automatic pesd_inc_t sel_count(input logic [7:0] v,
                                            input logic [7:0] m);
        pesd_inc_t n;
        n = '0;
        for (int i = 0; i < 8; i++) begin
            n = n + pesd_inc_t'(v[i] & m[i]);
        end
        return n;
    endfunction

    function automatic logic [31:0] strobe_merge(input logic [31:0] old_w,
                                                 input logic [31:0] new_w,
                                                 input logic [3:0] strb);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Event decode: each selected sub-event adds its own occurrences
    always_comb begin
        pesd_inc_t dsum;
        dsum = '0;
        raw_inc = '0;
        decoded = 1'b1;
        unique case (st_ff.code)
            EV_FPU_DISP: begin
                for (int p = 0; p < 3; p++) begin
                    // Mask bit p is plain ops, bit p+3 loads and SSE moves
                    if (events.disp_vld[p] &&
                        st_ff.mask[events.disp_ldmov[p] ? p + 3 : p]) begin
                        // A one-cycle dispatch; packed splits in two
                        dsum = dsum + ((events.disp_packed[p] &&
                                        FPU_DP_IS_64) ? 5'h02 : 5'h01);
                    end
                end
                raw_inc = dsum;
            end
            EV_FPU_EMPTY: begin
                raw_inc = pesd_inc_t'(events.fpu_empty);
            end
            EV_FAST_FLAG: begin
                raw_inc = pesd_inc_t'(events.fast_flag_cnt);
            end
            EV_SSE_RET: begin
                if (st_ff.mask[SSE_FLOP_BIT]) begin
                    // FLOP weighting can exceed the increment width when
                    // many classes retire together; it saturates
                    for (int c = 0; c < 6; c++) begin
                        if (events.sse_ret[c] && st_ff.mask[c]) begin
                            dsum = (dsum > 5'h18) ? 5'h1f :
                                dsum + pesd_inc_t'(events.sse_flops[c]);
                        end
                    end
                    raw_inc = dsum;
                end else begin
                    raw_inc = sel_count({2'h0, events.sse_ret},
                                        {2'h0, st_ff.mask[5:0]});
                end
            end
            EV_MOVE_RET: begin
                // Merging classes are tagged upstream by which half the
                // destination keeps untouched
                raw_inc = sel_count({4'h0, events.mov_ret},
                                    {4'h0, st_ff.mask[3:0]});
            end
            EV_SER_RET: begin
                raw_inc = sel_count({4'h0, events.ser_ret},
                                    {4'h0, st_ff.mask[3:0]});
            end
            EV_SER_SCHED: begin
                raw_inc = sel_count({6'h00, events.ser_in_sched},
                                    {6'h00, st_ff.mask[1:0]});
            end
            EV_SEG_LOAD: begin
                raw_inc = sel_count({1'b0, events.seg_load},
                                    {1'b0, st_ff.mask[6:0]});
            end
            EV_SMC_RESTART: begin
                raw_inc = pesd_inc_t'(events.smc_restart);
            end
            EV_PROBE_RESTART: begin
                raw_inc = pesd_inc_t'(events.probe_restart);
            end
            default: begin
                decoded = 1'b0;
                raw_inc = '0;
            end
        endcase
    end

    // Invert turns any event into a count of cycles without it; an
    // undecoded code stays silent even when inverted
    always_comb begin
        if (!st_ff.enable || !decoded) begin
            inc = '0;
        end else if (st_ff.invert) begin
            inc = pesd_inc_t'(raw_inc == '0);
        end else begin
            inc = raw_inc;
        end
    end

    // Serialization gates for the FP scheduler head
    assign bexec_issue_ok = sched.bexec_head &&
                            sched.bexec_oldest_unretired;
    assign bser_issue_ok = sched.bser_head &&
                           sched.bser_oldest_unissued;
    assign younger_block = sched.bser_head;

    // APB slave: no wait states; read data is captured into a flip-flop in the setup phase
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign mapped = (paddr == CTL_OFFSET) || (paddr == CTR_OFFSET) ||
                    (paddr == STAT_OFFSET);
    assign pready = access_ph;
    assign pslverr = access_ph && !mapped;
    assign prdata = st_ff.rdata;
    assign wr_ctl = access_ph && pwrite && (paddr == CTL_OFFSET);
    assign wr_ctr = access_ph && pwrite && (paddr == CTR_OFFSET);

    always_comb begin
        ctl_word = '0;
        ctl_word[CODE_LSB +: CODE_W] = st_ff.code;
        ctl_word[MASK_LSB +: MASK_W] = st_ff.mask;
        ctl_word[INVERT_BIT] = st_ff.invert;
        ctl_word[ENABLE_BIT] = st_ff.enable;
        ctl_new = strobe_merge(ctl_word, pwdata, pstrb);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.last_inc = inc;
        // Software load of the counter wins over this cycle's increment
        if (wr_ctr) begin
            nxt_st.count = strobe_merge(st_ff.count, pwdata, pstrb);
        end else begin
            nxt_st.count = st_ff.count + 32'(inc);
        end
        if (wr_ctl) begin
            nxt_st.code = ctl_new[CODE_LSB +: CODE_W];
            nxt_st.mask = ctl_new[MASK_LSB +: MASK_W];
            nxt_st.invert = ctl_new[INVERT_BIT];
            nxt_st.enable = ctl_new[ENABLE_BIT];
        end
        if (setup_ph && !pwrite) begin
            if (paddr == CTL_OFFSET) begin
                nxt_st.rdata = ctl_word;
            end else if (paddr == CTR_OFFSET) begin
                nxt_st.rdata = st_ff.count;
            end else if (paddr == STAT_OFFSET) begin
                nxt_st.rdata = {26'h0, decoded, st_ff.last_inc};
            end else begin
                nxt_st.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff.code <= CTL_RESET[CODE_LSB +: CODE_W];
            st_ff.mask <= CTL_RESET[MASK_LSB +: MASK_W];
            st_ff.invert <= CTL_RESET[INVERT_BIT];
            st_ff.enable <= CTL_RESET[ENABLE_BIT];
            st_ff.count <= CTR_RESET;
            st_ff.last_inc <= '0;
            st_ff.rdata <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic live;
    assign live = st_ff.enable && !wr_ctl;

    a_empty_plain: assert property (
        live && st_ff.code == EV_FPU_EMPTY && !st_ff.invert
        |=> st_ff.last_inc == pesd_inc_t'($past(events.fpu_empty)))
        else $error("empty cycle count wrong");

    a_empty_inverted: assert property (
        live && st_ff.code == EV_FPU_EMPTY && st_ff.invert
        |=> st_ff.last_inc == pesd_inc_t'(!$past(events.fpu_empty)))
        else $error("inverted empty count wrong");

    // Only the cycle right after an undecoded code is judged: a control
    // write in that cycle may legally bring a counting code next
    a_undecoded_silent: assert property (
        !decoded && !wr_ctr |=> st_ff.last_inc == '0 &&
        st_ff.count == $past(st_ff.count))
        else $error("undecoded code incremented");

    a_counter_accum: assert property (
        !wr_ctr |=> st_ff.count == $past(st_ff.count) + 32'(st_ff.last_inc))
        else $error("counter did not add increment");

    a_seg_sum: assert property (
        live && st_ff.code == EV_SEG_LOAD && !st_ff.invert
        |=> st_ff.last_inc ==
            pesd_inc_t'($countones($past(events.seg_load & st_ff.mask[6:0]))))
        else $error("segment load sum wrong");

    a_smc_restart: assert property (
        live && st_ff.code == EV_SMC_RESTART && !st_ff.invert
        |=> st_ff.last_inc == pesd_inc_t'($past(events.smc_restart)))
        else $error("self-modify restart count wrong");

    a_probe_restart: assert property (
        live && st_ff.code == EV_PROBE_RESTART && !st_ff.invert
        |=> st_ff.last_inc == pesd_inc_t'($past(events.probe_restart)))
        else $error("probe restart count wrong");

    a_packed_double: assert property (
        live && st_ff.code == EV_FPU_DISP && !st_ff.invert &&
        st_ff.mask[5:0] == 6'h01 && events.disp_vld[0] &&
        !events.disp_ldmov[0] && events.disp_packed[0]
        |=> st_ff.last_inc == 5'h02)
        else $error("packed dispatch not counted twice");

    a_bexec_hold: assert property (
        sched.bexec_head && !sched.bexec_oldest_unretired |-> !bexec_issue_ok)
        else $error("bottom-executing uop issued early");

    a_bser_block: assert property (
        sched.bser_head |-> younger_block &&
        (bser_issue_ok == sched.bser_oldest_unissued))
        else $error("bottom-serializing gate wrong");

    c_read_ctr: cover property (setup_ph && !pwrite && paddr == CTR_OFFSET
                                ##1 access_ph);
    c_multi_seg: cover property (live && st_ff.code == EV_SEG_LOAD &&
                                 sel_count({1'b0, events.seg_load},
                                           {1'b0, st_ff.mask[6:0]}) > 5'h1);
    c_flop_mode: cover property (live && st_ff.code == EV_SSE_RET &&
                                 st_ff.mask[SSE_FLOP_BIT] && inc > 5'h1);
    c_bad_addr: cover property (pslverr);

endmodule

// [verif/pesd_pipe_model.sv]
`timescale 1ns/1ns
module pesd_pipe_model (
    input wire logic busy,
    input wire logic [3:0] sched_pat,
    output pesd_pkg::pesd_events_s events,
    output pesd_pkg::pesd_sched_s sched
);
    import pesd_pkg::*;

    // Levels held for whole cycles; one fixed mix so each retire and segment
    // vector has both set and clear members and masks can tell them apart
    always_comb begin
        events = '0;
        events.fpu_empty = !busy;
        // Probe restarts come only while idle so both levels are seen
        events.probe_restart = !busy;
        if (busy) begin
            events.disp_vld = 3'h7;
            events.disp_ldmov = 3'h4;
            events.disp_packed = 3'h1;
            events.fast_flag_cnt = 2'h3;
            events.sse_ret = 6'h2b;
            events.sse_flops = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
            events.mov_ret = 4'hb;
            events.ser_ret = 4'h6;
            events.ser_in_sched = 2'h3;
            events.seg_load = 7'h55;
            events.smc_restart = 1'b1;
        end
    end

    assign sched = sched_pat;
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    import pesd_pkg::*;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy = 1'b0;
    logic [3:0] sched_pat = 4'h0;
    pesd_events_s events;
    pesd_sched_s sched;
    logic bexec_issue_ok;
    logic bser_issue_ok;
    logic younger_block;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    pesd_top pesd_top_i (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .sched(sched), .bexec_issue_ok(bexec_issue_ok),
        .bser_issue_ok(bser_issue_ok), .younger_block(younger_block));

    pesd_pipe_model pesd_pipe_model_i (.busy(busy), .sched_pat(sched_pat),
        .events(events), .sched(sched));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Plain APB master: the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_ctl(input logic [11:0] c, input logic [7:0] m,
                          input logic inv, input logic en);
        logic [31:0] v;
        logic [31:0] rd;
        logic er;
        v = '0;
        v[CODE_LSB +: CODE_W] = c;
        v[MASK_LSB +: MASK_W] = m;
        v[INVERT_BIT] = inv;
        v[ENABLE_BIT] = en;
        apb(1'b1, CTL_OFFSET, v, rd, er);
    endtask

    // Status is read one idle cycle after the control write lands
    task automatic ev(input logic [11:0] c, input logic [7:0] m,
                      input logic inv, input logic b, input logic dec,
                      input logic [4:0] e);
        logic [31:0] rd;
        logic er;
        busy <= b;
        wr_ctl(c, m, inv, 1'b1);
        apb(1'b0, STAT_OFFSET, 32'h0, rd, er);
        chk({26'h0, rd[5:0]}, {26'h0, dec, e});
    endtask

    task automatic t_reset;
        logic [31:0] rd;
        logic er;
        apb(1'b0, CTL_OFFSET, 32'h0, rd, er);
        chk(rd, CTL_RESET);
        apb(1'b0, CTR_OFFSET, 32'h0, rd, er);
        chk(rd, CTR_RESET);
        apb(1'b0, 12'h00c, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("reset and map test done");
    endtask

    task automatic t_events;
        ev(12'h000, 8'h3f, 0, 1, 1, 5'd4);
        ev(12'h000, 8'h01, 0, 1, 1, 5'd2);
        ev(12'h000, 8'h02, 0, 1, 1, 5'd1);
        ev(12'h000, 8'h04, 0, 1, 1, 5'd0);
        ev(12'h000, 8'h08, 0, 1, 1, 5'd0);
        ev(12'h000, 8'h20, 0, 1, 1, 5'd1);
        ev(12'h001, 8'h00, 0, 0, 1, 5'd1);
        ev(12'h001, 8'h00, 0, 1, 1, 5'd0);
        ev(12'h001, 8'h00, 1, 1, 1, 5'd1);
        ev(12'h002, 8'h00, 0, 1, 1, 5'd3);
        ev(12'h003, 8'h3f, 0, 1, 1, 5'd4);
        ev(12'h003, 8'h04, 0, 1, 1, 5'd0);
        ev(12'h003, 8'h7f, 0, 1, 1, 5'd13);
        ev(12'h003, 8'h48, 0, 1, 1, 5'd4);
        ev(12'h004, 8'h0f, 0, 1, 1, 5'd3);
        ev(12'h004, 8'h04, 0, 1, 1, 5'd0);
        ev(12'h005, 8'h0f, 0, 1, 1, 5'd2);
        ev(12'h005, 8'h09, 0, 1, 1, 5'd0);
        ev(12'h006, 8'h03, 0, 1, 1, 5'd2);
        ev(12'h006, 8'h02, 0, 1, 1, 5'd1);
        ev(12'h020, 8'h7f, 0, 1, 1, 5'd4);
        ev(12'h020, 8'h40, 0, 1, 1, 5'd1);
        ev(12'h020, 8'h02, 0, 1, 1, 5'd0);
        ev(12'h021, 8'h00, 0, 1, 1, 5'd1);
        ev(12'h021, 8'h00, 0, 0, 1, 5'd0);
        ev(12'h022, 8'h00, 0, 1, 1, 5'd0);
        ev(12'h022, 8'h00, 0, 0, 1, 5'd1);
        ev(12'h022, 8'h00, 1, 1, 1, 5'd1);
        ev(12'h007, 8'hff, 1, 1, 0, 5'd0);
        $display("event decode test done");
    endtask

    // Reads start three cycles apart, so the count moves by 12 per step
    task automatic t_counter;
        logic [31:0] r1;
        logic [31:0] r2;
        logic er;
        busy <= 1'b1;
        wr_ctl(12'h000, 8'h3f, 1'b0, 1'b1);
        apb(1'b1, CTR_OFFSET, 32'h100, r1, er);
        apb(1'b0, CTR_OFFSET, 32'h0, r1, er);
        apb(1'b0, CTR_OFFSET, 32'h0, r2, er);
        chk(r1, 32'h104);
        chk(r2 - r1, 32'd12);
        wr_ctl(12'h000, 8'h3f, 1'b0, 1'b0);
        apb(1'b0, CTR_OFFSET, 32'h0, r1, er);
        apb(1'b0, CTR_OFFSET, 32'h0, r2, er);
        chk(r2 - r1, 32'd0);
        // Byte lane 1 only: the other lanes keep the stopped count
        pstrb <= 4'h2;
        apb(1'b1, CTR_OFFSET, 32'h0000_ab00, r1, er);
        pstrb <= 4'hf;
        apb(1'b0, CTR_OFFSET, 32'h0, r1, er);
        chk(r1, {r2[31:16], 8'hab, r2[7:0]});
        $display("counter test done");
    endtask

    task automatic t_sched;
        for (int p = 0; p < 16; p++) begin
            sched_pat <= p[3:0];
            // Gates are combinational; look mid-cycle once they settle
            @(negedge clk);
            chk({31'h0, bexec_issue_ok}, {31'h0, p[3] & p[2]});
            chk({31'h0, bser_issue_ok}, {31'h0, p[1] & p[0]});
            chk({31'h0, younger_block}, {31'h0, p[1]});
            @(posedge clk);
        end
        $display("scheduler gate test done");
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_events();
        t_counter();
        t_sched();
        test_done();
    end
endmodule
